// ### rtl/msat_regs.svh
// constants of the microstep angle translator
// Functional notes
// - three-bit resolution select plus direction input
// - sixteenth mode steps angle by one
// - coarser modes step within allowed set
// - full one-phase uses 0,16,32,48
// - full two-phase uses 8,24,40,56
// - compensated half uses multiples of eight
// - uncompensated half drives full amplitude
// - quarter uses multiples of four
// - eighth uses even angles
// - fine modes use compensated table values
// - resolution change snaps to next allowed
// - home is 8, or 0 one-phase
// - single-step arithmetic wraps modulo 64
// - increment is six-bit two's complement
// - single step on strobe rising edge
// - phase magnitude six bits plus sign
`ifndef MSAT_REGS_SVH
`define MSAT_REGS_SVH
`define MSAT_HOME_ANGLE 6'h08
`define MSAT_HOME_ONE_PHASE 6'h00
`define MSAT_FULL_SCALE 6'h3F
`define MSAT_RES_FULL1 3'h0
`define MSAT_RES_FULL2 3'h1
`define MSAT_RES_HALF_COMP 3'h2
`define MSAT_RES_HALF_UNCOMP 3'h3
`define MSAT_RES_QUARTER 3'h4
`define MSAT_RES_EIGHTH 3'h5
`define MSAT_RES_SIXTEENTH 3'h6
`endif

// ### rtl/msat_pkg.sv
// types of the microstep angle translator
package msat_pkg;
  // one phase current reference
  typedef struct packed {
    logic       neg;
    logic [5:0] mag;
  } msat_phase_t;
  // both phase references together
  typedef struct packed {
    msat_phase_t a;
    msat_phase_t b;
  } msat_phases_t;
endpackage : msat_pkg

// ### rtl/msat_phase_table.sv
// sine table lookup from step angle to phase references
`timescale 1ns/1ps
`default_nettype none
`include "msat_regs.svh"
module msat_phase_table
  import msat_pkg::*;
(
  // lookup
  input wire logic [5:0] i_angle,
  input wire logic i_uncomp,
  output msat_phases_t o_phases
);
  // first-quadrant magnitudes, index 0..16
  function automatic logic [5:0] quad_mag(input logic [4:0] k);
    logic [5:0] m;
    m = 6'h00;
    unique case (k)
      5'h00: m = 6'h00;
      5'h01: m = 6'h05;
      5'h02: m = 6'h0B;
      5'h03: m = 6'h12;
      5'h04: m = 6'h17;
      5'h05: m = 6'h1D;
      5'h06: m = 6'h23;
      5'h07: m = 6'h28;
      5'h08: m = 6'h2C;
      5'h09: m = 6'h30;
      5'h0A: m = 6'h34;
      5'h0B: m = 6'h37;
      5'h0C: m = 6'h3A;
      5'h0D: m = 6'h3C;
      5'h0E: m = 6'h3E;
      5'h0F: m = 6'h3F;
      default: m = 6'h3F;
    endcase
    return m;
  endfunction
  // offset within quadrant and its mirror
  logic [3:0] off;
  logic [4:0] up;
  logic [4:0] down;
  logic [5:0] mag_a;
  logic [5:0] mag_b;
  // a follows sine, b follows cosine
  always_comb begin
    off = i_angle[3:0];
    up = {1'b0, off};
    down = 5'h10 - {1'b0, off};
    if (i_angle[4] == 1'b0) begin
      mag_a = quad_mag(up);
      mag_b = quad_mag(down);
    end else begin
      mag_a = quad_mag(down);
      mag_b = quad_mag(up);
    end
    if (i_uncomp) begin
      // full amplitude on every active phase
      mag_a = (mag_a != 6'h00) ? `MSAT_FULL_SCALE : 6'h00;
      mag_b = (mag_b != 6'h00) ? `MSAT_FULL_SCALE : 6'h00;
    end
    o_phases.a.mag = mag_a;
    o_phases.b.mag = mag_b;
    // a negative from just past 32 through 63, b from just past 16 through 48
    o_phases.a.neg = i_angle[5] && (i_angle != 6'h20);
    o_phases.b.neg = (i_angle > 6'h10) && (i_angle <= 6'h30);
  end
endmodule : msat_phase_table
`default_nettype wire

// ### rtl/msat_translator.sv
// step angle counter with sequencer and single-step moves
`timescale 1ns/1ps
`default_nettype none
`include "msat_regs.svh"
module msat_translator
  import msat_pkg::*;
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_arst_n,
  // sequencer step and configuration
  input wire logic i_step,
  input wire logic i_direction,
  input wire logic [2:0] i_resolution_select,
  input wire logic i_wake,
  // single-step write from the serial block
  input wire logic i_serial_strobe_low,
  input wire logic i_increment_written,
  input wire logic [5:0] i_single_step_increment,
  // outputs
  output logic [5:0] o_angle,
  output msat_phases_t o_phases
);
  // allowed-set stride for a resolution
  function automatic logic [5:0] stride(input logic [2:0] r);
    logic [5:0] s;
    s = 6'h01;
    unique case (r)
      `MSAT_RES_FULL1, `MSAT_RES_FULL2: s = 6'h10;
      `MSAT_RES_HALF_COMP, `MSAT_RES_HALF_UNCOMP: s = 6'h08;
      `MSAT_RES_QUARTER: s = 6'h04;
      `MSAT_RES_EIGHTH: s = 6'h02;
      default: s = 6'h01;
    endcase
    return s;
  endfunction
  // next allowed angle in travel direction
  function automatic logic [5:0] next_angle(input logic [5:0] a, input logic [2:0] r,
                                            input logic fwd);
    logic [5:0] s;
    logic [5:0] base;
    logic [5:0] rel;
    logic [5:0] q;
    s = stride(r);
    // two-phase grid sits half a full step above zero
    base = (r == `MSAT_RES_FULL2) ? 6'h08 : 6'h00;
    rel = a - base;
    // round down onto the grid of this resolution
    q = rel & ~(s - 6'h01);
    // forward always leaves for the next grid point
    if (fwd) begin
      q = q + s;
    end else if (q == rel) begin
      // already on the grid: one stride back
      q = q - s;
    end
    return q + base;
  endfunction
  // three-flop sync on strobe and step pins
  logic [2:0] strb_sync_ff;
  logic [2:0] step_sync_ff;
  // settled pin levels
  logic strb_lvl_ff;
  logic step_lvl_ff;
  logic armed_ff; // increment written this frame
  // step angle counter
  logic [5:0] angle_ff;
  logic home_pend_ff; // home load requested
  // next values
  logic [5:0] nxt_angle;
  logic nxt_armed;
  logic nxt_strb_lvl;
  logic nxt_step_lvl;
  logic nxt_home_pend;
  // one-cycle rising edges of the settled levels
  logic strb_rise;
  logic step_rise;
  // table lookup of the next angle
  msat_phases_t phases_now;
  // next-state computation
  // priority: home, then strobe move, then step move
  // a step edge meeting a strobe move in one cycle is lost
  always_comb begin
    nxt_strb_lvl = strb_lvl_ff;
    nxt_step_lvl = step_lvl_ff;
    // level changes once second and third agree
    if (strb_sync_ff[1] == strb_sync_ff[2]) begin
      nxt_strb_lvl = strb_sync_ff[2];
    end
    if (step_sync_ff[1] == step_sync_ff[2]) begin
      nxt_step_lvl = step_sync_ff[2];
    end
    strb_rise = nxt_strb_lvl && !strb_lvl_ff;
    step_rise = nxt_step_lvl && !step_lvl_ff;
    // by default every state holds, except the home request, which clears
    nxt_armed = armed_ff;
    nxt_home_pend = 1'b0;
    nxt_angle = angle_ff;
    // a written field arms the next strobe rise
    if (i_increment_written) begin
      nxt_armed = 1'b1;
    end
    if (home_pend_ff || i_wake) begin
      // home position, 0 only for one-phase full step
      nxt_angle = (i_resolution_select == `MSAT_RES_FULL1) ?
                  `MSAT_HOME_ONE_PHASE : `MSAT_HOME_ANGLE;
      nxt_armed = 1'b0;
    end else if (strb_rise && armed_ff) begin
      // signed add wraps naturally in six bits
      nxt_angle = angle_ff + i_single_step_increment;
      // a field written in this very cycle stays armed
      nxt_armed = i_increment_written;
    end else if (step_rise) begin
      // sequencer move to the neighbouring grid point
      nxt_angle = next_angle(angle_ff, i_resolution_select, i_direction);
    end
  end
  // register everything
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      // idle levels, so no false edge after release
      strb_sync_ff <= 3'h7;
      step_sync_ff <= 3'h0;
      strb_lvl_ff <= 1'b1;
      step_lvl_ff <= 1'b0;
      armed_ff <= 1'b0;
      angle_ff <= `MSAT_HOME_ANGLE;
      // home waits for the first edge after release
      home_pend_ff <= 1'b1;
      o_angle <= `MSAT_HOME_ANGLE;
      o_phases <= '0;
    end else begin
      // pins move one stage per edge
      strb_sync_ff <= {strb_sync_ff[1:0], i_serial_strobe_low};
      step_sync_ff <= {step_sync_ff[1:0], i_step};
      strb_lvl_ff <= nxt_strb_lvl;
      step_lvl_ff <= nxt_step_lvl;
      armed_ff <= nxt_armed;
      angle_ff <= nxt_angle;
      home_pend_ff <= nxt_home_pend;
      o_angle <= nxt_angle;
      o_phases <= phases_now;
    end
  end
  // uncompensated half step looks up full amplitude
  msat_phase_table u_table (
    .i_angle(nxt_angle),
    .i_uncomp(i_resolution_select == `MSAT_RES_HALF_UNCOMP),
    .o_phases(phases_now)
  );
  // sixteenth forward step adds exactly one
  a_sixteenth_fwd: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (step_rise && !strb_rise && !home_pend_ff && !i_wake && i_direction &&
     i_resolution_select == `MSAT_RES_SIXTEENTH) |=> (angle_ff == $past(angle_ff) + 6'h01))
    else $error("sixteenth step did not add one");
  // full two-phase lands on odd multiple of eight
  a_full_two_set: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (step_rise && !home_pend_ff && !i_wake && !(strb_rise && armed_ff) &&
     i_resolution_select == `MSAT_RES_FULL2) |=> (angle_ff[3:0] == 4'h8))
    else $error("two-phase angle outside set");
  // quarter steps land on multiples of four
  a_quarter_set: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (step_rise && !home_pend_ff && !i_wake && !(strb_rise && armed_ff) &&
     i_resolution_select == `MSAT_RES_QUARTER) |=> (angle_ff[1:0] == 2'h0))
    else $error("quarter angle outside set");
  // single step adds the increment
  a_single_add: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (strb_rise && armed_ff && !home_pend_ff && !i_wake) |=>
    (angle_ff == $past(angle_ff) + $past(i_single_step_increment)))
    else $error("single step sum wrong");
  // no move without step or strobe
  a_angle_hold: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (!step_rise && !strb_rise && !home_pend_ff && !i_wake) |=> $stable(angle_ff))
    else $error("angle moved without cause");
  // wake loads home
  a_wake_home: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (i_wake && i_resolution_select != `MSAT_RES_FULL1) |=> (angle_ff == 6'h08))
    else $error("home not loaded");
  // phase references follow the counter in the same cycle
  a_out_track: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (o_angle == 6'h00) |->
    (o_phases.a.mag == 6'h00 && o_phases.b.mag == `MSAT_FULL_SCALE && !o_phases.b.neg))
    else $error("phase references lag the angle");
  // uncompensated phase a magnitude is zero or full
  a_uncomp_full: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (i_resolution_select == `MSAT_RES_HALF_UNCOMP) |=>
    (o_phases.a.mag == 6'h00 || o_phases.a.mag == 6'h3F || $past(home_pend_ff)))
    else $error("uncompensated amplitude reduced");
  // sixteenth reverse step takes exactly one away
  a_sixteenth_back: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (step_rise && !strb_rise && !home_pend_ff && !i_wake && !i_direction &&
     i_resolution_select == `MSAT_RES_SIXTEENTH) |=> (angle_ff == $past(angle_ff) - 6'h01))
    else $error("sixteenth step did not take one away");
  // one-phase full steps land on multiples of sixteen
  a_one_phase_set: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (step_rise && !home_pend_ff && !i_wake && !(strb_rise && armed_ff) &&
     i_resolution_select == `MSAT_RES_FULL1) |=> (angle_ff[3:0] == 4'h0))
    else $error("one-phase angle outside set");
  // compensated half steps land on multiples of eight
  a_half_comp_set: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (step_rise && !home_pend_ff && !i_wake && !(strb_rise && armed_ff) &&
     i_resolution_select == `MSAT_RES_HALF_COMP) |=> (angle_ff[2:0] == 3'h0))
    else $error("half-step angle outside set");
  // eighth steps land on even angles
  a_eighth_set: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (step_rise && !home_pend_ff && !i_wake && !(strb_rise && armed_ff) &&
     i_resolution_select == `MSAT_RES_EIGHTH) |=> (angle_ff[0] == 1'b0))
    else $error("eighth angle outside set");
  // forward from the top grid point wraps to zero
  a_forward_wrap: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (step_rise && !home_pend_ff && !i_wake && !(strb_rise && armed_ff) && i_direction &&
     i_resolution_select == `MSAT_RES_HALF_COMP && angle_ff[5:3] == 3'h7) |=>
    (angle_ff == 6'h00))
    else $error("sequencer did not wrap to zero");
  // strobe rise without a written field moves nothing
  a_unarmed_hold: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (strb_rise && !armed_ff && !step_rise && !home_pend_ff && !i_wake) |=> $stable(angle_ff))
    else $error("unarmed strobe moved the angle");
  // wake in one-phase mode loads zero
  a_home_one_phase: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (i_wake && i_resolution_select == `MSAT_RES_FULL1) |=> (angle_ff == 6'h00))
    else $error("one-phase home not loaded");
  // exactly one phase carries current at each detent
  a_one_phase_zero: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (o_angle[3:0] == 4'h0) |->
    ((o_phases.a.mag == 6'h00) != (o_phases.b.mag == 6'h00)))
    else $error("detent does not use exactly one phase");
endmodule : msat_translator
`default_nettype wire

// ### bench/msat_host_model.sv
// host model: single-step frames on the serial strobe
`timescale 1ns/1ps
`default_nettype none
module msat_host_model (
  // clock
  input wire logic i_clock,
  // serial side
  output logic o_serial_strobe_low,
  output logic o_increment_written,
  output logic [5:0] o_single_step_increment
);
  // idle: strobe high, no write
  initial begin
    o_serial_strobe_low = 1'b1;
    o_increment_written = 1'b0;
    o_single_step_increment = 6'h00;
  end
  // one frame; wr low sends a frame with no increment write
  task automatic send(input logic [5:0] inc, input logic wr);
    @(negedge i_clock);
    o_serial_strobe_low = 1'b0;
    o_single_step_increment = inc;
    repeat (2) @(negedge i_clock);
    o_increment_written = wr;
    @(negedge i_clock);
    o_increment_written = 1'b0;
    repeat (2) @(negedge i_clock);
    // rising strobe ends the frame and sets the step time
    o_serial_strobe_low = 1'b1;
    repeat (6) @(negedge i_clock);
    // field no longer held: show the inverse
    o_single_step_increment = ~inc;
  endtask
endmodule // msat_host_model
`default_nettype wire

// ### bench/tb_microstep_angle_translator.sv
// testbench of the step angle translator
`timescale 1ns/1ps
`default_nettype none
module tb_microstep_angle_translator
  import msat_pkg::*;
();
  logic clock = 1'b0; // 50 MHz
  logic arst_n = 1'b0; // reset, low active
  logic step = 1'b0; // step pin
  logic direction = 1'b1; // 1 forward
  logic [2:0] res = 3'h6; // resolution code
  logic wake = 1'b0; // home reload
  logic strobe_low; // host strobe
  logic written; // host write pulse
  logic [5:0] inc; // host increment
  logic [5:0] angle; // angle seen
  msat_phases_t phases; // references seen
  int errors = 0;
  int checks = 0;
  int cycles = 0;
  logic [5:0] fwd [8] = '{6'h10, 6'h18, 6'h10, 6'h10, 6'h0C, 6'h0A, 6'h09, 6'h09};
  always #10 clock = ~clock;
  msat_host_model host (.i_clock(clock), .o_serial_strobe_low(strobe_low),
    .o_increment_written(written), .o_single_step_increment(inc));
  msat_translator DUT (.i_clock(clock), .i_arst_n(arst_n), .i_step(step),
    .i_direction(direction), .i_resolution_select(res), .i_wake(wake),
    .i_serial_strobe_low(strobe_low), .i_increment_written(written),
    .i_single_step_increment(inc), .o_angle(angle), .o_phases(phases));
  // compare and count
  task automatic check(input logic [13:0] seen, input logic [13:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  // step pin high 3 cycles, low until settled
  task automatic pulse_step();
    @(negedge clock);
    step = 1'b1;
    repeat (3) @(negedge clock);
    step = 1'b0;
    repeat (5) @(negedge clock);
  endtask
  // home reload
  task automatic wake_pulse();
    @(negedge clock);
    wake = 1'b1;
    @(negedge clock);
    wake = 1'b0;
    @(negedge clock);
  endtask
  // home after reset and after wake
  task automatic t_home();
    check({8'h00, angle}, 14'h0008, "home");
    check(phases, {1'b0, 6'h2C, 1'b0, 6'h2C}, "home phases");
    res = 3'h0;
    wake_pulse();
    check({8'h00, angle}, 14'h0000, "one-phase home");
    check(phases, {1'b0, 6'h00, 1'b0, 6'h3F}, "angle 0 phases");
    $display("test home done");
  endtask
  // every resolution code: one step forward, one back
  task automatic t_modes();
    for (int k = 0; k < 8; k++) begin
      res = k[2:0];
      wake_pulse();
      direction = 1'b1;
      pulse_step();
      check({8'h00, angle}, {8'h00, fwd[k]}, "forward");
      direction = 1'b0;
      pulse_step();
      check({8'h00, angle}, (k == 0) ? 14'h0000 : 14'h0008, "back");
      if (k == 3) check(phases, {1'b0, 6'h3F, 1'b0, 6'h3F}, "uncomp");
      if (k == 4) check(phases, {1'b0, 6'h2C, 1'b0, 6'h2C}, "comp");
    end
    $display("test modes done");
  endtask
  // off-grid angles snap on resolution change
  task automatic t_snap();
    res = 3'h6;
    wake_pulse();
    host.send(6'h31, 1'b1);
    check({8'h00, angle}, 14'h0039, "minus 15");
    direction = 1'b1;
    res = 3'h4;
    pulse_step();
    check({8'h00, angle}, 14'h003C, "to quarter");
    res = 3'h2;
    pulse_step();
    check({8'h00, angle}, 14'h0000, "to half");
    host.send(6'h3F, 1'b1);
    check({8'h00, angle}, 14'h003F, "0 minus 1");
    direction = 1'b0;
    res = 3'h5;
    pulse_step();
    check({8'h00, angle}, 14'h003E, "reverse snap");
    $display("test snap done");
  endtask
  // single-step frames, with and without a written field
  task automatic t_single();
    res = 3'h6;
    wake_pulse();
    host.send(6'h04, 1'b1);
    check({8'h00, angle}, 14'h000C, "plus 4");
    host.send(6'h3C, 1'b1);
    check({8'h00, angle}, 14'h0008, "minus 4");
    host.send(6'h10, 1'b0);
    check({8'h00, angle}, 14'h0008, "no write");
    host.send(6'h30, 1'b1);
    check({8'h00, angle}, 14'h0038, "minus 16");
    check(phases, {1'b1, 6'h2C, 1'b0, 6'h2C}, "angle 56 phases");
    $display("test single done");
  endtask
  // counts and verdict
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // cut a hang short
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      tally_and_finish();
    end
  end
  // main sequence
  initial begin
    repeat (3) @(negedge clock);
    arst_n = 1'b1;
    repeat (2) @(negedge clock);
    t_home();
    t_modes();
    t_snap();
    t_single();
    tally_and_finish();
  end
endmodule // tb_microstep_angle_translator
`default_nettype wire
